// ==== shared/nc_status_pkg.sv ====
package nc_status_pkg;
    localparam int AXIS_COUNT = 8;
    localparam int SYSTEM_COUNT = 2;
    localparam logic [3:0] INIT_TYPE_MARKED = 4'h2;
    localparam logic [7:0] POLY_AXIS_SPINDLE = 8'h00;
    localparam int ALARM_SOURCE_COUNT = 6;
    localparam int SYNC_STAGES = 3;
    localparam logic FLAG_RESET = 1'b0;
endpackage

// ==== src/axis_init_flags.sv ====
`timescale 1ns/1ps
`default_nettype none
module axis_init_flags
    import nc_status_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic initTypeMarked,
    input wire logic axisInitModeSelect,
    input wire logic axisInitStart,
    input wire logic coordEstablished,
    input wire logic initImpossible,
    input wire logic gridPassed,
    input wire logic gridCheckRequired,
    input wire logic emergencyStop,
    input wire logic ncReset,
    input wire logic powerOn,
    output logic axisInitDone,
    output logic axisInitError
);
    logic startPrev_reg;
    logic modeFirst_reg;
    logic startRise;
    logic errorValid;

    assign startRise = axisInitStart && !startPrev_reg;

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            startPrev_reg <= FLAG_RESET;
        else
            startPrev_reg <= axisInitStart;
    end

    // mode must be seen before start rises
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            modeFirst_reg <= FLAG_RESET;
        else if (!axisInitStart)
            modeFirst_reg <= axisInitModeSelect;
        else if (!axisInitModeSelect)
            modeFirst_reg <= 1'b0;
    end

    assign errorValid = !emergencyStop && !ncReset // [RL4]
        && modeFirst_reg && axisInitModeSelect // [RL5]
        && (gridPassed || !gridCheckRequired); // [RL6]

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            axisInitDone <= FLAG_RESET; // [RL15]
        else if (powerOn || startRise)
            axisInitDone <= 1'b0; // [RL2]
        else if (initTypeMarked && coordEstablished && axisInitModeSelect)
            axisInitDone <= 1'b1; // [RL1]
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            axisInitError <= FLAG_RESET;
        else if (!errorValid || powerOn)
            axisInitError <= 1'b0; // [RL4] [RL5] [RL6]
        else if (startRise)
            axisInitError <= initImpossible; // [RL3]
    end
endmodule
`default_nettype wire

// ==== src/nc_status_flag_logic.sv ====
// Contract
// RL1: an axis done flag rises when its coordinate system is established, only for init type 2; the logic also requires axisInitModeSelect high.
// RL2: an axis done flag clears when that axis is initialized again or power is reapplied.
// RL3: on a start rising edge the axis error flag sets if initialization is impossible.
// RL4: the error flag is invalid during emergency stop and during reset.
// RL5: mode must precede start; start before mode makes the error flag invalid.
// RL6: the error flag is invalid when no grid was passed and the detector needs one.
// RL7: polygon axis parameter nonzero picks spindle-NC polygon, zero picks spindle-spindle.
// RL8: the spindle-NC polygon flag sets on polygon start and holds through the mode.
// RL9: the spindle-NC polygon flag clears on cancel or reset and stays clear otherwise.
// RL10: the alarm flag is on only while enable bit is set and some listed alarm exists.
// RL11: the alarm flag ORs interlock, override zero, feed zero, two block interlocks, polygon.
// RL12: the spindle-spindle flag sets on polygon start while spindle-spindle is selected.
// RL13: the spindle-spindle flag clears on cancel, sync cancel, emergency stop or reset.
// RL14: eight axes of init flags and a full flag set for each of two systems.
// RL15: all flags update on the clock and clear on system reset.
`timescale 1ns/1ps
`default_nettype none
module nc_status_flag_logic
    import nc_status_pkg::*;
#(
    parameter int AXES = AXIS_COUNT,
    parameter int SYSTEMS = SYSTEM_COUNT
)
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [3:0] initType,
    input wire logic powerOn,
    input wire logic [SYSTEMS*AXES-1:0] axisInitModeSelect,
    input wire logic [SYSTEMS*AXES-1:0] axisInitStart,
    input wire logic [SYSTEMS*AXES-1:0] coordEstablished,
    input wire logic [SYSTEMS*AXES-1:0] initImpossible,
    input wire logic [SYSTEMS*AXES-1:0] gridPassed,
    input wire logic [SYSTEMS*AXES-1:0] gridCheckRequired,
    input wire logic [SYSTEMS-1:0] emergencyStop,
    input wire logic [SYSTEMS-1:0] ncReset,
    input wire logic [SYSTEMS*8-1:0] polygonAxis,
    input wire logic [SYSTEMS-1:0] polygonStart,
    input wire logic [SYSTEMS-1:0] polygonCancel,
    input wire logic [SYSTEMS-1:0] spindleSyncCancel,
    input wire logic [SYSTEMS-1:0] alarmOutputEnableBit,
    input wire logic [SYSTEMS*ALARM_SOURCE_COUNT-1:0] alarmSources,
    output logic [SYSTEMS*AXES-1:0] axisInitDone,
    output logic [SYSTEMS*AXES-1:0] axisInitError,
    output logic [SYSTEMS-1:0] polygonNcAxisMode,
    output logic [SYSTEMS-1:0] polygonSpindleMode,
    output logic [SYSTEMS-1:0] operationAlarmFlag
);
    logic initTypeMarked;
    assign initTypeMarked = (initType == INIT_TYPE_MARKED);

    ////////////////////////////////////////////////////////////////////////////////
    genvar s, a;
    generate
        for (s = 0; s < SYSTEMS; s++)
        begin : g_sys
            logic ncAxisSelected;
            logic alarmAny;
            assign ncAxisSelected = (polygonAxis[s*8 +: 8] != POLY_AXIS_SPINDLE); // [RL7]
            assign alarmAny = |alarmSources[s*ALARM_SOURCE_COUNT +: ALARM_SOURCE_COUNT]; // [RL11]

            for (a = 0; a < AXES; a++)
            begin : g_axis
                axis_init_flags u_axis ( // [RL14]
                    .ref_clk(ref_clk),
                    .reset_n(reset_n),
                    .initTypeMarked(initTypeMarked),
                    .axisInitModeSelect(axisInitModeSelect[s*AXES+a]),
                    .axisInitStart(axisInitStart[s*AXES+a]),
                    .coordEstablished(coordEstablished[s*AXES+a]),
                    .initImpossible(initImpossible[s*AXES+a]),
                    .gridPassed(gridPassed[s*AXES+a]),
                    .gridCheckRequired(gridCheckRequired[s*AXES+a]),
                    .emergencyStop(emergencyStop[s]),
                    .ncReset(ncReset[s]),
                    .powerOn(powerOn),
                    .axisInitDone(axisInitDone[s*AXES+a]),
                    .axisInitError(axisInitError[s*AXES+a])
                );
            end

            always_ff @(posedge ref_clk or negedge reset_n)
            begin
                if (!reset_n)
                    polygonNcAxisMode[s] <= FLAG_RESET; // [RL15]
                else if (polygonCancel[s] || ncReset[s] || !ncAxisSelected)
                    polygonNcAxisMode[s] <= 1'b0; // [RL9]
                else if (polygonStart[s])
                    polygonNcAxisMode[s] <= 1'b1; // [RL8]
            end

            always_ff @(posedge ref_clk or negedge reset_n)
            begin
                if (!reset_n)
                    polygonSpindleMode[s] <= FLAG_RESET;
                else if (polygonCancel[s] || spindleSyncCancel[s] || emergencyStop[s]
                    || ncReset[s] || ncAxisSelected)
                    polygonSpindleMode[s] <= 1'b0; // [RL13]
                else if (polygonStart[s])
                    polygonSpindleMode[s] <= 1'b1; // [RL12]
            end

            always_ff @(posedge ref_clk or negedge reset_n)
            begin
                if (!reset_n)
                    operationAlarmFlag[s] <= FLAG_RESET;
                else
                    operationAlarmFlag[s] <= alarmOutputEnableBit[s] && alarmAny; // [RL10]
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ==== sim/nc_status_flag_logic_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module nc_status_flag_logic_asserts
(
    input wire logic ref_clk, reset_n, powerOn,
    input wire logic [15:0] axisInitModeSelect, axisInitStart, polygonAxis, axisInitDone,
    input wire logic [15:0] axisInitError,
    input wire logic [1:0] emergencyStop, ncReset, polygonStart, polygonCancel, spindleSyncCancel,
    input wire logic [1:0] alarmOutputEnableBit, polygonNcAxisMode, polygonSpindleMode,
    input wire logic [1:0] operationAlarmFlag,
    input wire logic [11:0] alarmSources
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    AST_ALM: assert property (1 |=> operationAlarmFlag[0] ==
        $past(alarmOutputEnableBit[0] & |alarmSources[5:0])) else $error("alarm flag wrong");
    AST_ALM_OFF: assert property (!alarmOutputEnableBit[1] |=> !operationAlarmFlag[1])
        else $error("alarm not masked");
    AST_ERR_STOP: assert property (emergencyStop[0] | ncReset[0] |=> !axisInitError[7:0])
        else $error("error flag during stop");
    AST_ERR_ORD: assert property (axisInitStart[0] & !axisInitModeSelect[0]
        |=> !axisInitError[0]) else $error("error flag without mode");
    AST_PWR: assert property (powerOn |=> !axisInitDone & !axisInitError)
        else $error("flags kept over power on");
    AST_NC_CLR: assert property (polygonCancel[0] | ncReset[0] |=> !polygonNcAxisMode[0])
        else $error("nc polygon flag kept");
    AST_SP_CLR: assert property (|{polygonCancel[1], spindleSyncCancel[1], emergencyStop[1],
        ncReset[1]} |=> !polygonSpindleMode[1]) else $error("spindle polygon flag kept");
    AST_SP_SET: assert property ($rose(polygonSpindleMode[0]) |-> $past(polygonStart[0]) &&
        $past(polygonAxis[7:0]) == 8'h00) else $error("spindle polygon flag cause");
    AST_NC_SET: assert property ($rose(polygonNcAxisMode[1]) |-> $past(polygonStart[1]) &&
        $past(polygonAxis[15:8]) != 8'h00) else $error("nc polygon flag cause");
    cover property (operationAlarmFlag[0]);
    cover property (polygonSpindleMode[1]);
    cover property ($rose(axisInitError[0]));
endmodule
bind nc_status_flag_logic nc_status_flag_logic_asserts chk (.*);
`default_nettype wire

// ==== sim/plc_seq_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module plc_seq_model
(
    input wire logic ref_clk,
    input wire logic [15:0] initReq,
    output logic [15:0] axisInitModeSelect = '0,
    output logic [15:0] axisInitStart = '0
);
    // mode goes up one cycle ahead of start
    always @(negedge ref_clk)
    begin
        axisInitModeSelect <= initReq;
        axisInitStart <= initReq & axisInitModeSelect;
    end
endmodule
`default_nettype wire

// ==== sim/nc_status_flag_logic_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module nc_status_flag_logic_tb;
    logic ref_clk = 0, reset_n = 0, powerOn = 0;
    logic [3:0] initType = 4'h2;
    logic [15:0] initReq = '0, axisInitModeSelect, axisInitStart, coordEstablished = '0;
    logic [15:0] initImpossible = '0, gridPassed = '0, gridCheckRequired = '0, polygonAxis = '0;
    logic [15:0] axisInitDone, axisInitError;
    logic [11:0] alarmSources = '0;
    logic [1:0] emergencyStop = '0, ncReset = '0, polygonStart = '0, polygonCancel = '0;
    logic [1:0] spindleSyncCancel = '0, alarmOutputEnableBit = '0;
    logic [1:0] polygonNcAxisMode, polygonSpindleMode, operationAlarmFlag, expNc, expSp, expAl;
    int fails = 0, samples_checked = 0, cyc = 0;
    always #20 ref_clk = ~ref_clk;
    plc_seq_model plc (.ref_clk, .initReq, .axisInitModeSelect, .axisInitStart);
    nc_status_flag_logic uut (.*);
    always @(posedge ref_clk or negedge reset_n)
        for (int s = 0; s < 2; s++)
        begin
            expAl[s] <= reset_n && alarmOutputEnableBit[s] && alarmSources[s*6+:6] != 0;
            expNc[s] <= reset_n && polygonAxis[s*8+:8] != 0 && !polygonCancel[s] && !ncReset[s]
                && (polygonStart[s] || expNc[s]);
            expSp[s] <= reset_n && polygonAxis[s*8+:8] == 0 && !polygonCancel[s] && !ncReset[s]
                && !spindleSyncCancel[s] && !emergencyStop[s] && (polygonStart[s] || expSp[s]);
        end
    always @(posedge ref_clk)
        if (++cyc == 3000)
        begin
            fails++;
            wrap_up();
        end
    task cmp(input string n, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task tick(input int k);
        repeat (k) @(negedge ref_clk);
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        void'($urandom(49330));
        tick(3);
        reset_n = 1;
        repeat (400)
        begin
            tick(1);
            cmp("alarm", 16'(expAl), 16'(operationAlarmFlag));
            cmp("ncMode", 16'(expNc), 16'(polygonNcAxisMode));
            cmp("spMode", 16'(expSp), 16'(polygonSpindleMode));
            {polygonStart, spindleSyncCancel, alarmOutputEnableBit} = 6'($urandom);
            polygonCancel = 2'($urandom & $urandom & $urandom);
            ncReset = 2'($urandom & $urandom & $urandom);
            emergencyStop = 2'($urandom & $urandom & $urandom);
            alarmSources = 12'($urandom & $urandom);
            if ($urandom % 8 == 0)
                polygonAxis = 16'($urandom) & {{8{1'($urandom)}}, {8{1'($urandom)}}};
        end
        {polygonStart, polygonCancel, spindleSyncCancel, ncReset, emergencyStop} = '0;
        reset_n = 0;
        tick(1);
        cmp("resetFlags", 16'h0, 16'({operationAlarmFlag, polygonNcAxisMode, polygonSpindleMode}));
        reset_n = 1;
        $display("polygon and alarm test done");
        gridCheckRequired = 16'hFF00;
        initImpossible = 16'hFFFF;
        initReq <= 16'hFFFF;
        tick(4);
        cmp("initError", 16'h00FF, axisInitError);
        emergencyStop = 2'h1;
        tick(2);
        cmp("errorStop", 16'h0, axisInitError);
        emergencyStop = 2'h0;
        coordEstablished = 16'hFFFF;
        tick(2);
        cmp("initDone", 16'hFFFF, axisInitDone);
        powerOn = 1;
        tick(2);
        cmp("donePower", 16'h0, axisInitDone);
        powerOn = 0;
        initType = 4'h3;
        tick(3);
        cmp("doneType", 16'h0, axisInitDone);
        $display("init flag test done");
        wrap_up();
    end
endmodule
`default_nettype wire
